// >>> rtl/watchdog_unit_pkg.sv
// Constants and carrier types for the watchdog control block.
package watchdog_unit_pkg;

  // ==========================================================
  // Register map and layout
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h97;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h17;
  localparam int INTERVAL_LSB = 0;
  localparam int INTERVAL_MSB = 2;
  localparam int ACTIVE_BIT = 4;
  localparam int CMD_FLAG_BIT = 7;
  localparam logic [2:0] INTERVAL_RESET = 3'h7;

  // ==========================================================
  // Command codes written to the control register
  localparam logic [7:0] CMD_RELOAD = 8'hA5;
  localparam logic [7:0] CMD_DISABLE_FIRST = 8'hDE;
  localparam logic [7:0] CMD_DISABLE_SECOND = 8'hAD;
  localparam logic [7:0] CMD_LOCK = 8'hFF;

  // ==========================================================
  // Timing
  localparam logic [2:0] DISABLE_WINDOW_CYCLES = 3'h4;
  localparam int INTERVAL_EXP_OFFSET = 3;
  localparam int COUNT_WIDTH = 21;

  // Special-function register access from the core.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// >>> rtl/watchdog_timer_control.sv
// Watchdog timer with its single command/status control register.
//
// Summary of operation
// - Reading control returns the programmed interval code in bits 2:0.
// - Reading control returns one in bit 4 while the watchdog runs.
// - Any write with bit 7 clear loads the interval from bits 2:0.
// - Watchdog stops only when 0xDE then 0xAD arrive within 4 cycles.
// - Writing 0xFF locks out every disable sequence until device reset.
// - Writing 0xA5 starts the watchdog and restarts its count from zero.
// - Timeout is four to the power (interval code plus three) slow periods.
// - Count reaching the timeout without reload raises a system reset.
// - The 0xFF lock write neither starts nor reloads the watchdog.
`timescale 1ns/1ps

module watchdog_timer_control
  import watchdog_unit_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire watchdog_unit_pkg::sfr_req_t SFR_REQ,
  input wire logic LOW_FREQ_OSC,
  output logic [7:0] SFR_RDATA,
  output logic RESET_REQUEST,
  output logic OSC_FORCE_ON
);
  import watchdog_unit_pkg::*;

  // ==========================================================
  // Reset release and slow oscillator synchronisers
  logic rst_meta;
  logic rst_n;
  logic lf_meta;
  logic lf_sync;
  logic lf_prev;

  // Reset asserts at once but releases only after two clean edges.
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // The slow clock is sampled, not used as a clock, so one domain remains.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_meta <= 1'b0;
      lf_sync <= 1'b0;
      lf_prev <= 1'b0;
    end
    else
    begin
      lf_meta <= LOW_FREQ_OSC;
      lf_sync <= lf_meta;
      lf_prev <= lf_sync;
    end
  end

  // ==========================================================
  // Write decoding
  logic [2:0] interval;
  logic running;
  logic lock;
  logic [2:0] arm;
  logic [COUNT_WIDTH-1:0] count;
  logic tripped;

  wire logic hit = SFR_REQ.addr == WATCHDOG_CONTROL_ADDR;
  wire logic hit_wr = hit && SFR_REQ.wr;
  wire logic hit_rd = hit && SFR_REQ.rd;
  wire logic wr_interval = hit_wr && !SFR_REQ.wdata[CMD_FLAG_BIT];
  wire logic wr_reload = hit_wr && SFR_REQ.wdata == CMD_RELOAD;
  wire logic wr_first = hit_wr && SFR_REQ.wdata == CMD_DISABLE_FIRST;
  wire logic wr_second = hit_wr && SFR_REQ.wdata == CMD_DISABLE_SECOND;
  wire logic wr_lock = hit_wr && SFR_REQ.wdata == CMD_LOCK;
  wire logic lf_tick = lf_sync && !lf_prev;
  // The second half counts only while the window from 0xDE is open.
  wire logic stop_ok = wr_second && arm != 3'h0 && !lock;
  wire logic [4:0] shift = 5'((interval + 3'(INTERVAL_EXP_OFFSET)) * 2);
  wire logic [COUNT_WIDTH-1:0] limit = COUNT_WIDTH'(1) << shift;
  wire logic [7:0] read_value =
    {3'h0, running, 1'b0, interval};

  // ==========================================================
  // Interval and run state
  // interval load, reset value.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      interval <= INTERVAL_RESET;
    else if (wr_interval)
      interval <= SFR_REQ.wdata[INTERVAL_MSB:INTERVAL_LSB];
  end

  // start, stop; a lock write leaves the run state alone.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      running <= 1'b1;
    else if (wr_reload)
      running <= 1'b1;
    else if (stop_ok)
      running <= 1'b0;
  end

  // lock holds until the next device reset.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      lock <= 1'b0;
    else if (wr_lock)
      lock <= 1'b1;
  end

  // disable window: any other write to the control register closes it early.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      arm <= 3'h0;
    else if (wr_first)
      arm <= DISABLE_WINDOW_CYCLES;
    else if (hit_wr)
      arm <= 3'h0;
    else if (arm != 3'h0)
      arm <= arm - 3'h1;
  end

  // ==========================================================
  // Timeout counter
  // counting slow periods; restart from zero.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (wr_reload)
      count <= '0;
    else if (running && lf_tick && count < limit)
      count <= count + COUNT_WIDTH'(1);
  end

  // overflow; sticky so the reset request cannot be missed.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      tripped <= 1'b0;
    else if (running && count >= limit && !wr_reload)
      tripped <= 1'b1;
  end

  // ==========================================================
  // Registered outputs
  // read data is latched in the cycle after the read strobe.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SFR_RDATA <= 8'h00;
      RESET_REQUEST <= 1'b0;
      OSC_FORCE_ON <= 1'b0;
    end
    else
    begin
      SFR_RDATA <= hit_rd ? read_value : 8'h00;
      RESET_REQUEST <= tripped;
      OSC_FORCE_ON <= running; // Slow oscillator stays on while active.
    end
  end

  // ==========================================================
  // Checks
  property p_read_interval;
    @(posedge CLOCK) disable iff (!rst_n)
    hit_rd |=> SFR_RDATA[2:0] == $past(interval);
  endproperty
  a_read_interval: assert property (p_read_interval)
    else $error("Read did not return the interval code.");

  property p_read_active;
    @(posedge CLOCK) disable iff (!rst_n)
    hit_rd |=> SFR_RDATA[ACTIVE_BIT] == $past(running);
  endproperty
  a_read_active: assert property (p_read_active)
    else $error("Read did not return the active flag.");

  property p_interval_load;
    @(posedge CLOCK) disable iff (!rst_n)
    wr_interval |=> interval == $past(SFR_REQ.wdata[2:0]);
  endproperty
  a_interval_load: assert property (p_interval_load)
    else $error("Interval write was not taken.");

  property p_stop_cause;
    @(posedge CLOCK) disable iff (!rst_n)
    $fell(running) |-> $past(wr_second) && $past(arm) != 3'h0
      && !$past(lock);
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("Watchdog stopped without a timely disable pair.");

  property p_late_second;
    @(posedge CLOCK) disable iff (!rst_n)
    (wr_first ##1 !hit_wr [*4] ##1 wr_second) |=> $stable(running);
  endproperty
  a_late_second: assert property (p_late_second)
    else $error("Late disable pair stopped the watchdog.");

  property p_lock_holds;
    @(posedge CLOCK) disable iff (!rst_n)
    lock |=> lock && !$fell(running);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("Locked watchdog was released or stopped.");

  property p_reload;
    @(posedge CLOCK) disable iff (!rst_n)
    wr_reload |=> running && count == '0;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Reload did not start and clear the count.");

  // A lowered interval may leave the count above the new limit, so only
  // a count that has just moved up is held against the limit it saw.
  property p_limit;
    @(posedge CLOCK) disable iff (!rst_n)
    count > $past(count) |-> count <= $past(limit);
  endproperty
  a_limit: assert property (p_limit)
    else $error("Count passed the programmed timeout.");

  property p_trip;
    @(posedge CLOCK) disable iff (!rst_n)
    (running && count >= limit && !wr_reload) |=> ##1 RESET_REQUEST;
  endproperty
  a_trip: assert property (p_trip)
    else $error("Timeout did not raise the reset request.");

  property p_lock_write;
    @(posedge CLOCK) disable iff (!rst_n)
    wr_lock |=> lock && running == $past(running)
      && count >= $past(count);
  endproperty
  a_lock_write: assert property (p_lock_write)
    else $error("Lock write changed the run state or count.");

  property p_reset_state;
    @(posedge CLOCK) disable iff (!rst_n)
    $rose(rst_n) |-> running && !lock && interval == INTERVAL_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Reset did not leave the watchdog running.");

endmodule

// >>> verification/watchdog_timer_control_bench.sv
// Self-checking bench for the watchdog control block.
`timescale 1ns/1ps

module watchdog_timer_control_bench;
  import watchdog_unit_pkg::*;
  localparam logic [7:0] A = WATCHDOG_CONTROL_ADDR;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  sfr_req_t sfr_req = '0;
  logic low_freq_osc = 1'b0;
  logic [7:0] sfr_rdata;
  logic reset_request;
  logic osc_force_on;
  int bad_count = 0;
  int checks_done = 0;

  // ==========================================================
  // Clock and block under test
  // Free-running system clock, 10 ns period.
  initial
  begin
    forever #5 clock = ~clock;
  end

  watchdog_timer_control watchdog_timer_control_inst (
    .CLOCK(clock),
    .RESET_N(reset_n),
    .SFR_REQ(sfr_req),
    .LOW_FREQ_OSC(low_freq_osc),
    .SFR_RDATA(sfr_rdata),
    .RESET_REQUEST(reset_request),
    .OSC_FORCE_ON(osc_force_on)
  );

  // ==========================================================
  // Helpers
  // Expected read byte built from the running flag and interval.
  function automatic logic [7:0] rv(input logic run, input logic [2:0] ivl);
    rv = 8'h00;
    rv[ACTIVE_BIT] = run;
    rv[INTERVAL_MSB:INTERVAL_LSB] = ivl;
  endfunction

  // Case equality, so an unknown never passes for a match.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Releases the bus and lets n edges pass.
  task automatic gap(input int n);
    sfr_req = '0;
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Leaves wr high so two calls give back-to-back writes.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    #1;
  endtask

  task automatic cmd(input logic [7:0] v);
    wr(A, v);
    gap(1);
  endtask

  // Read data stands just after the taking edge; look there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    #1;
    sfr_req = '0;
    chk(sfr_rdata, exp);
    @(posedge clock);
    #1;
  endtask

  // Rising edges of the slow oscillator, four system clocks apart.
  task automatic slow(input int n);
    repeat (n)
    begin
      low_freq_osc = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      low_freq_osc = 1'b0;
      repeat (2) @(posedge clock);
      #1;
    end
  endtask

  // ==========================================================
  // Scenarios
  // A hang anywhere is cut short here and counted as a mismatch.
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end

  // Main sequence; the disable window is probed at both of its edges.
  initial
  begin
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    gap(4);
    rd(A, WATCHDOG_CONTROL_RESET);
    chk({7'h00, osc_force_on}, 8'h01);
    rd(8'h96, 8'h00);
    wr(8'h96, 8'h02);
    gap(1);
    rd(A, rv(1'b1, 3'h7));
    cmd(8'h02);
    rd(A, rv(1'b1, 3'h2));
    wr(A, CMD_DISABLE_FIRST);
    gap(4);
    wr(A, CMD_DISABLE_SECOND);
    gap(2);
    rd(A, rv(1'b1, 3'h2));
    wr(A, CMD_DISABLE_FIRST);
    wr(A, CMD_DISABLE_SECOND);
    gap(2);
    chk({7'h00, osc_force_on}, 8'h00);
    rd(A, rv(1'b0, 3'h2));
    cmd(8'h85);
    rd(A, rv(1'b0, 3'h2));
    cmd(CMD_LOCK);
    rd(A, rv(1'b0, 3'h2));
    cmd(CMD_RELOAD);
    rd(A, rv(1'b1, 3'h2));
    wr(A, CMD_DISABLE_FIRST);
    wr(A, CMD_DISABLE_SECOND);
    gap(2);
    rd(A, rv(1'b1, 3'h2));
    cmd(8'h00);
    cmd(CMD_RELOAD);
    slow(63);
    gap(10);
    chk({7'h00, reset_request}, 8'h00);
    slow(1);
    // Sample off the edge so the flop has settled before it is read.
    for (int i = 0; i < 20 && reset_request !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    chk({7'h00, reset_request}, 8'h01);
    if (reset_request !== 1'b1)
      final_report();
    // A second reset must clear the trip and the lock.
    reset_n = 1'b0;
    gap(2);
    chk({7'h00, reset_request}, 8'h00);
    reset_n = 1'b1;
    gap(4);
    rd(A, WATCHDOG_CONTROL_RESET);
    wr(A, CMD_DISABLE_FIRST);
    wr(A, CMD_DISABLE_SECOND);
    gap(2);
    rd(A, rv(1'b0, 3'h7));
    final_report();
  end
endmodule
